// ### core/sem_host.sv
// Purpose: Controller for one port of a dual-port RAM with hardware semaphores
// Assumes: Device pins are asynchronous; data and busy inputs are synchronised
// Notes:   Semaphore index sits in the low three address bits
// Operation
// - Hold address and enable until busy settles, then start write pulse.
// - Exactly one cascaded part is master, all others slaves.
// - Deassert select or output enable between repeated semaphore reads.
// - Acquire by writing zero then reading back; never read first.
// - After failed request keep reading or write one to release.
// - At power-up write one to every semaphore so all are free.
`timescale 1ns/10ps
`default_nettype none

module sem_host
  import sem_host_pkg::*;
#(
  parameter int unsigned MAX_POLLS = 4,
  parameter bit          IS_MASTER = 1'b1
)
(
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic              cmd_valid_in,
  input  wire cmd_t              cmd_in,
  output logic                   cmd_ready_out,
  output logic                   done_out,
  output result_t                result_out,
  output logic                   chip_enable_n_out,
  output logic                   semaphore_select_n_out,
  output logic                   output_enable_n_out,
  output logic                   write_n_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe_out,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic              port_busy_line_n_in,
  output logic                   master_select_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [DATA_W-1:0] data_meta_reg;
  logic [DATA_W-1:0] data_sync_reg;
  logic              busy_meta_reg;
  logic              busy_sync_reg;

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      data_meta_reg <= '0;
      data_sync_reg <= '0;
      busy_meta_reg <= 1'b1;
      busy_sync_reg <= 1'b1;
    end
    else
    begin
      data_meta_reg <= data_in;
      data_sync_reg <= data_meta_reg;
      busy_meta_reg <= port_busy_line_n_in;
      busy_sync_reg <= busy_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cascade strap

  always_ff @(posedge clk_in)
    master_select_out <= IS_MASTER;

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer

  state_t            state_reg;
  act_t              act_reg;
  op_t               op_reg;
  logic [3:0]        cnt_reg;
  logic [2:0]        idx_reg;
  logic [7:0]        poll_reg;
  logic              giveup_reg;
  logic [DATA_W-1:0] wdata_reg;

  assign cmd_ready_out = (state_reg == ST_IDLE);

  function automatic logic [ADDR_W-1:0] sem_addr(input logic [2:0] idx);
    sem_addr = {{(ADDR_W-3){1'b0}}, idx};
  endfunction : sem_addr

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      state_reg              <= ST_IDLE;
      act_reg                <= ACT_DONE;
      op_reg                 <= OP_INIT;
      cnt_reg                <= '0;
      idx_reg                <= '0;
      poll_reg               <= '0;
      giveup_reg             <= 1'b0;
      wdata_reg              <= '0;
      done_out               <= 1'b0;
      result_out             <= '0;
      chip_enable_n_out      <= 1'b1;
      semaphore_select_n_out <= 1'b1;
      output_enable_n_out    <= 1'b1;
      write_n_out            <= 1'b1;
      addr_out               <= '0;
      data_out               <= '0;
      data_oe_out            <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      unique case (state_reg)
        ST_IDLE:
        begin
          if (cmd_valid_in)
          begin
            op_reg       <= cmd_in.op;
            idx_reg      <= cmd_in.addr[2:0];
            poll_reg     <= '0;
            giveup_reg   <= 1'b0;
            result_out   <= '0;
            cnt_reg      <= '0;
            state_reg    <= ST_GAP;
            unique case (cmd_in.op)
              OP_INIT:
              begin
                idx_reg   <= '0;
                wdata_reg <= FREE_BYTE;
                act_reg   <= ACT_WRITE;
              end
              OP_ACQUIRE:
              begin
                wdata_reg <= TAKE_BYTE;
                act_reg   <= ACT_WRITE;
              end
              OP_RELEASE:
              begin
                wdata_reg <= FREE_BYTE;
                act_reg   <= ACT_WRITE;
              end
              OP_POLL:
                act_reg <= ACT_READ;
              OP_RAM_WR:
              begin
                chip_enable_n_out <= 1'b0;
                addr_out          <= cmd_in.addr;
                data_out          <= cmd_in.data;
                data_oe_out       <= 1'b1;
                cnt_reg           <= SETUP_CYC;
                state_reg         <= ST_SETUP;
              end
              OP_RAM_RD:
              begin
                chip_enable_n_out   <= 1'b0;
                output_enable_n_out <= 1'b0;
                addr_out            <= cmd_in.addr;
                cnt_reg             <= ACCESS_CYC;
                state_reg           <= ST_READ;
              end
              default:
              begin
                act_reg <= ACT_DONE;
              end
            endcase
          end
        end
        ST_SETUP:
        begin
          if (cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
          else if (op_reg != OP_RAM_WR || busy_sync_reg)
          begin
            write_n_out <= 1'b0;
            cnt_reg     <= PULSE_CYC;
            state_reg   <= ST_PULSE;
          end
        end
        ST_PULSE:
        begin
          if (cnt_reg > 4'h1)
            cnt_reg <= cnt_reg - 4'h1;
          else
          begin
            write_n_out <= 1'b1;
            state_reg   <= ST_END;
          end
        end
        ST_END:
        begin
          chip_enable_n_out      <= 1'b1;
          semaphore_select_n_out <= 1'b1;
          data_oe_out            <= 1'b0;
          cnt_reg                <= RECOVER_CYC;
          state_reg              <= ST_GAP;
          if (op_reg == OP_INIT && idx_reg != LAST_SEM)
          begin
            idx_reg <= idx_reg + 3'h1;
            act_reg <= ACT_WRITE;
          end
          else if (op_reg == OP_ACQUIRE && !giveup_reg)
            act_reg <= ACT_READ;
          else
            act_reg <= ACT_DONE;
        end
        ST_READ:
        begin
          if (cnt_reg > 4'h1)
            cnt_reg <= cnt_reg - 4'h1;
          else
          begin
            output_enable_n_out    <= 1'b1;
            semaphore_select_n_out <= 1'b1;
            chip_enable_n_out      <= 1'b1;
            result_out.rdata       <= data_sync_reg;
            cnt_reg                <= RECOVER_CYC;
            state_reg              <= ST_GAP;
            act_reg                <= ACT_DONE;
            if (op_reg == OP_ACQUIRE)
            begin
              if (!data_sync_reg[0])
                result_out.granted <= 1'b1;
              else if (poll_reg == 8'(MAX_POLLS - 1))
              begin
                giveup_reg <= 1'b1;
                wdata_reg  <= FREE_BYTE;
                act_reg    <= ACT_WRITE;
              end
              else
              begin
                poll_reg <= poll_reg + 8'h1;
                act_reg  <= ACT_READ;
              end
            end
          end
        end
        ST_GAP:
        begin
          if (cnt_reg > 4'h1)
            cnt_reg <= cnt_reg - 4'h1;
          else
          begin
            unique case (act_reg)
              ACT_WRITE:
              begin
                semaphore_select_n_out <= 1'b0;
                addr_out               <= sem_addr(idx_reg);
                data_out               <= wdata_reg;
                data_oe_out            <= 1'b1;
                cnt_reg                <= SETUP_CYC;
                state_reg              <= ST_SETUP;
              end
              ACT_READ:
              begin
                semaphore_select_n_out <= 1'b0;
                output_enable_n_out    <= 1'b0;
                addr_out               <= sem_addr(idx_reg);
                cnt_reg                <= ACCESS_CYC;
                state_reg              <= ST_READ;
              end
              default:
              begin
                done_out  <= 1'b1;
                state_reg <= ST_IDLE;
              end
            endcase
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule : sem_host

`default_nettype wire

// ### core/sem_host_pkg.sv
// Purpose: Shared types and constants for the semaphore port controller
// Assumes: 200 MHz clock; one port of the dual-port part is driven
// Notes:   Times are least times, rounded up to whole cycles
package sem_host_pkg;

  localparam int unsigned CLK_MHZ    = 200;
  localparam int unsigned SETUP_NS   = 10;
  localparam int unsigned PULSE_NS   = 15;
  localparam int unsigned ACCESS_NS  = 20;
  localparam int unsigned RECOVER_NS = 5;

  localparam logic [3:0] SETUP_CYC   = 4'((SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] PULSE_CYC   = 4'((PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] SYNC_CYC    = 4'h2;
  localparam logic [3:0] ACCESS_CYC  = 4'((ACCESS_NS * CLK_MHZ + 999) / 1000) + SYNC_CYC;
  localparam logic [3:0] RECOVER_CYC = 4'((RECOVER_NS * CLK_MHZ + 999) / 1000);

  localparam int unsigned ADDR_W   = 13;
  localparam int unsigned DATA_W   = 8;
  localparam logic [2:0]  LAST_SEM = 3'h7;
  localparam logic [7:0]  FREE_BYTE = 8'hFF;
  localparam logic [7:0]  TAKE_BYTE = 8'h00;

  typedef enum logic [2:0]
  {
    OP_INIT    = 3'b000,
    OP_ACQUIRE = 3'b001,
    OP_RELEASE = 3'b010,
    OP_POLL    = 3'b011,
    OP_RAM_WR  = 3'b100,
    OP_RAM_RD  = 3'b101
  } op_t;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_PULSE = 3'b010,
    ST_END   = 3'b011,
    ST_READ  = 3'b100,
    ST_GAP   = 3'b101
  } state_t;

  typedef enum logic [1:0]
  {
    ACT_DONE  = 2'b00,
    ACT_READ  = 2'b01,
    ACT_WRITE = 2'b10
  } act_t;

  typedef struct packed
  {
    op_t               op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cmd_t;

  typedef struct packed
  {
    logic              granted;
    logic [DATA_W-1:0] rdata;
  } result_t;

endpackage : sem_host_pkg

// ### tb/sem_dev_model.sv
// Purpose: Behavioural dual-port part, left port faces the host
// Assumes: Right port is commanded by the bench
// Notes:   Start state arbitrary: flags held left, right pending
`timescale 1ns/10ps
`default_nettype none
module sem_dev_model
  import sem_host_pkg::*;
(
  input  wire logic              ce_n_in,
  input  wire logic              sem_n_in,
  input  wire logic              oe_n_in,
  input  wire logic              write_n_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic              master_in,
  input  wire logic              busy_n_in,
  input  wire logic              right_wr_in,
  input  wire logic [2:0]        right_idx_in,
  input  wire logic              right_bit_in,
  output logic [DATA_W-1:0]      data_out,
  output logic [7:0]             right_flags_out
);
  logic [7:0] req_l = 8'h00, req_r = 8'h00, own_l = 8'hFF, own_r = 8'h00;
  logic [7:0] q = 8'hFF;
  logic [7:0] mem [16];
  wire        sem_rd = sem_n_in | oe_n_in;
  wire        ram_rd = ce_n_in | oe_n_in;
  wire        wr_ok  = master_in | busy_n_in;
  assign right_flags_out = ~own_r;
  assign data_out = (!sem_rd || !ram_rd) ? q : ~q;
  always @(negedge sem_rd or negedge ram_rd)
  begin
    if (!sem_rd)
      q = {8{~own_l[addr_in[2:0]]}};
    else
      q = mem[addr_in[3:0]];
  end
  always @(posedge write_n_in or posedge right_wr_in)
  begin
    if (right_wr_in)
      req_r[right_idx_in] = right_bit_in;
    else if (wr_ok && !sem_n_in)
      req_l[addr_in[2:0]] = data_in[0];
    else if (wr_ok && !ce_n_in)
      mem[addr_in[3:0]] = data_in;
    for (int i = 0; i < 8; i++)
    begin
      if (own_l[i] && req_l[i])
        own_l[i] = 1'b0;
      if (own_r[i] && req_r[i])
        own_r[i] = 1'b0;
      if (!own_l[i] && !own_r[i])
      begin
        own_l[i] = !req_l[i];
        own_r[i] = req_l[i] && !req_r[i];
      end
    end
  end
endmodule : sem_dev_model
`default_nettype wire

// ### tb/sem_host_asserts.sv
// Purpose: Port checks for sem_host
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every sem_host instance
`timescale 1ns/10ps
`default_nettype none
module sem_host_asserts
  import sem_host_pkg::*;
#(parameter bit IS_MASTER = 1'b1)
(
  input wire logic              clk_in,
  input wire logic              resetn_in,
  input wire logic              done_out,
  input wire result_t           result_out,
  input wire logic              chip_enable_n_out,
  input wire logic              semaphore_select_n_out,
  input wire logic              output_enable_n_out,
  input wire logic              write_n_out,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_oe_out,
  input wire logic              port_busy_line_n_in,
  input wire logic              master_select_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_select_one: assert property (!(!chip_enable_n_out && !semaphore_select_n_out))
    else $error("both selects low");
  a_write_drives: assert property (!write_n_out |-> data_oe_out && output_enable_n_out)
    else $error("write without data drive");
  a_write_stable: assert property (!write_n_out && !$past(write_n_out) |-> $stable(addr_out) && $stable(data_out))
    else $error("address or data moved in pulse");
  a_pulse_width: assert property ($fell(write_n_out) |-> (!write_n_out)[*3] ##1 write_n_out)
    else $error("write pulse width");
  a_read_hold: assert property ($fell(output_enable_n_out) |-> (!output_enable_n_out)[*6] ##1 output_enable_n_out)
    else $error("read strobe width");
  a_busy_stall: assert property ((!port_busy_line_n_in)[*4] ##0 !chip_enable_n_out |=> !$fell(write_n_out))
    else $error("write started under busy");
  a_standby_quiet: assert property (chip_enable_n_out && semaphore_select_n_out |-> output_enable_n_out && write_n_out)
    else $error("strobe without select");
  a_master_strap: assert property (master_select_out == IS_MASTER)
    else $error("master strap wrong");
  a_done_pulse: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  c_granted: cover property (done_out && result_out.granted);
  c_sem_write: cover property (!semaphore_select_n_out && !write_n_out);
  c_ram_write: cover property (!chip_enable_n_out && !write_n_out);
endmodule : sem_host_asserts
bind sem_host sem_host_asserts #(.IS_MASTER(IS_MASTER)) i_chk (.clk_in(clk_in), .resetn_in(resetn_in),
  .done_out(done_out), .result_out(result_out), .chip_enable_n_out(chip_enable_n_out),
  .semaphore_select_n_out(semaphore_select_n_out), .output_enable_n_out(output_enable_n_out),
  .write_n_out(write_n_out), .addr_out(addr_out), .data_out(data_out), .data_oe_out(data_oe_out),
  .port_busy_line_n_in(port_busy_line_n_in), .master_select_out(master_select_out));
`default_nettype wire

// ### tb/sem_host_tb.sv
// Purpose: Self-checking bench for sem_host
// Assumes: Device model on the far side, right port driven here
// Notes:   MAX_POLLS shortened to 2
`timescale 1ns/10ps
`default_nettype none
module sem_host_tb;
  import sem_host_pkg::*;
  logic clk_in, resetn_in, cmd_valid, busy_n, right_wr, right_bit;
  logic [2:0] right_idx;
  cmd_t cmd;
  result_t res;
  logic ready, done, ce_n, sem_n, oe_n, we_n, d_oe, mst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] hd, dd;
  logic [7:0] rflags;
  int fail_count = 0, check_count = 0, cycles = 0;
  sem_host #(.MAX_POLLS(2)) i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .cmd_valid_in(cmd_valid),
    .cmd_in(cmd), .cmd_ready_out(ready), .done_out(done), .result_out(res), .chip_enable_n_out(ce_n),
    .semaphore_select_n_out(sem_n), .output_enable_n_out(oe_n), .write_n_out(we_n), .addr_out(addr),
    .data_out(hd), .data_oe_out(d_oe), .data_in(dd), .port_busy_line_n_in(busy_n), .master_select_out(mst));
  sem_dev_model i_dev (.ce_n_in(ce_n), .sem_n_in(sem_n), .oe_n_in(oe_n), .write_n_in(we_n), .addr_in(addr),
    .data_in(hd), .master_in(mst), .busy_n_in(busy_n), .right_wr_in(right_wr), .right_idx_in(right_idx),
    .right_bit_in(right_bit), .data_out(dd), .right_flags_out(rflags));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic start_cmd(input op_t op, input logic [12:0] a, input logic [7:0] d);
    @(posedge clk_in);
    cmd_valid <= 1'b1;
    cmd <= '{op, a, d};
    @(posedge clk_in);
    cmd_valid <= 1'b0;
  endtask : start_cmd
  task automatic wait_done();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_in);
      #1;
      n++;
    end while (done !== 1'b1 && n < 2000);
    chk("done", done, 8'h01);
    chk("ready", ready, 8'h01);
  endtask : wait_done
  task automatic do_cmd(input op_t op, input logic [12:0] a, input logic [7:0] d);
    start_cmd(op, a, d);
    wait_done();
  endtask : do_cmd
  task automatic right_op(input logic [2:0] i, input logic b);
    @(posedge clk_in);
    right_idx <= i;
    right_bit <= b;
    @(posedge clk_in);
    right_wr <= 1'b1;
    @(posedge clk_in);
    right_wr <= 1'b0;
  endtask : right_op
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_init();
    do_cmd(OP_INIT, 13'h0000, 8'h00);
    for (int i = 0; i < 8; i++)
      right_op(3'(i), 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      do_cmd(OP_POLL, {10'h2AA, 3'(i)}, 8'h00);
      chk("poll free", res.rdata, FREE_BYTE);
    end
    chk("right flags", rflags, 8'hFF);
    $display("test init done");
  endtask : t_init
  task automatic t_handover();
    do_cmd(OP_ACQUIRE, 13'h1FFB, 8'h00);
    chk("granted", res.granted, 8'h01);
    chk("acq byte", res.rdata, TAKE_BYTE);
    chk("sem addr", addr[10:3], 8'h00);
    chk("other side", rflags[3], 8'h01);
    right_op(3'h3, 1'b0);
    chk("pending", rflags[3], 8'h01);
    do_cmd(OP_RELEASE, 13'h0003, 8'h00);
    chk("passed", rflags[3], 8'h00);
    do_cmd(OP_POLL, 13'h0003, 8'h00);
    chk("left sees one", res.rdata, FREE_BYTE);
    right_op(3'h3, 1'b1);
    chk("freed", rflags, 8'hFF);
    $display("test handover done");
  endtask : t_handover
  task automatic t_contend();
    right_op(3'h5, 1'b0);
    do_cmd(OP_ACQUIRE, 13'h0005, 8'h00);
    chk("refused", res.granted, 8'h00);
    chk("refused byte", res.rdata, FREE_BYTE);
    chk("request dropped", i_dev.req_l[5], 8'h01);
    right_op(3'h5, 1'b1);
    do_cmd(OP_ACQUIRE, 13'h0005, 8'h00);
    chk("retry", res.granted, 8'h01);
    do_cmd(OP_RELEASE, 13'h0005, 8'h00);
    chk("all free", rflags, 8'hFF);
    $display("test contend done");
  endtask : t_contend
  task automatic t_ram();
    @(posedge clk_in);
    busy_n <= 1'b0;
    start_cmd(OP_RAM_WR, 13'h0002, 8'hA5);
    repeat (20) @(posedge clk_in);
    #1;
    chk("stalled strobe", we_n, 8'h01);
    chk("stalled done", done, 8'h00);
    chk("stalled ready", ready, 8'h00);
    @(posedge clk_in);
    busy_n <= 1'b1;
    wait_done();
    do_cmd(OP_RAM_RD, 13'h0002, 8'h00);
    chk("ram data", res.rdata, 8'hA5);
    $display("test ram done");
  endtask : t_ram
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  initial
  begin
    resetn_in = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    busy_n = 1'b1;
    right_wr = 1'b0;
    right_bit = 1'b1;
    right_idx = 3'h0;
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_init();
    t_handover();
    t_contend();
    t_ram();
    report_and_stop();
  end
endmodule : sem_host_tb
`default_nettype wire
